// File: imp_pkg.sv
// Constants and types shared by the indirect pointer map
package imp_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address on the bus is four times these)
    // ------------------------------------------------------------
    localparam int          IDX_W         = 11;
    localparam [IDX_W-1:0]  IDX_IND0      = 11'h400;  // Indirect port zero
    localparam [IDX_W-1:0]  IDX_IND1      = 11'h401;  // Indirect port one
    localparam [IDX_W-1:0]  IDX_P0L       = 11'h404;  // Pointer zero low
    localparam [IDX_W-1:0]  IDX_P0H       = 11'h405;  // Pointer zero high
    localparam [IDX_W-1:0]  IDX_P1L       = 11'h406;  // Pointer one low
    localparam [IDX_W-1:0]  IDX_P1H       = 11'h407;  // Pointer one high
    localparam [IDX_W-1:0]  IDX_BSR       = 11'h408;  // Bank selector
    localparam [IDX_W-1:0]  IDX_STAT      = 11'h410;  // Block status
    localparam int          AXI_AW        = 13;       // Bus address width

    // ------------------------------------------------------------
    // Core register offsets inside every bank
    // ------------------------------------------------------------
    localparam int          OFF_W         = 7;
    localparam [OFF_W-1:0]  OFF_IND0      = IDX_IND0[OFF_W-1:0];
    localparam [OFF_W-1:0]  OFF_IND1      = IDX_IND1[OFF_W-1:0];
    localparam [OFF_W-1:0]  OFF_P0L       = IDX_P0L[OFF_W-1:0];
    localparam [OFF_W-1:0]  OFF_P0H       = IDX_P0H[OFF_W-1:0];
    localparam [OFF_W-1:0]  OFF_P1L       = IDX_P1L[OFF_W-1:0];
    localparam [OFF_W-1:0]  OFF_P1H       = IDX_P1H[OFF_W-1:0];
    localparam [OFF_W-1:0]  OFF_BSR       = IDX_BSR[OFF_W-1:0];

    // ------------------------------------------------------------
    // Pointer address space
    // ------------------------------------------------------------
    localparam int          BANK_W        = 5;
    localparam int          MADDR_W       = BANK_W + OFF_W;
    localparam int          FADDR_W       = 15;
    localparam int          FWORD_W       = 14;
    localparam int          FLASH_BIT     = 15;       // Pointer bit selecting flash
    localparam [15:0]       LIN_BASE      = 16'h2000; // First linear pointer
    localparam [15:0]       LIN_END       = 16'h29AF; // Last linear pointer
    localparam [15:0]       GPR_BYTES     = 16'h0050; // RAM bytes per bank
    localparam [15:0]       GPR_OFF       = 16'h0020; // First RAM byte in a bank
    localparam [BANK_W-1:0] IMPL_BANKS    = 5'h02;    // Banks backed by real RAM
    localparam [15:0]       PTR_RST       = 16'h0000;
    localparam [BANK_W-1:0] BSR_RST       = 5'h00;
    localparam [7:0]        ZERO_BYTE     = 8'h00;

    // ------------------------------------------------------------
    // Bus responses and state
    // ------------------------------------------------------------
    localparam [1:0]        RESP_OKAY     = 2'h0;
    localparam [1:0]        RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {K_MEM, K_FLASH, K_ZERO} imp_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_XTRA, ST_RESP} imp_state_t;

    // Result of decoding one pointer
    typedef struct packed {
        imp_kind_t            kind;
        logic [MADDR_W-1:0]   maddr;
        logic [FADDR_W-1:0]   faddr;
    } imp_map_t;

endpackage : imp_pkg

// File: imp_pointer_map.sv
// Indirect pointer map with core access port and bus register slave
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Port zero redirects through pointer zero
// - Port one redirects through pointer one
// - Core registers answer in every bank
// - Linear pointers map onto each bank's RAM
// - Linear increment crosses into next bank
// - Unbacked linear location reads zero
// - Common bytes excluded from linear map
// - Pointer top bit selects flash address
// - Flash read returns word's low byte
// - Indirect flash write changes nothing
// - Flash access takes one extra cycle
module imp_pointer_map (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Core access port
    input  wire logic                        core_req,
    input  wire logic                        core_we,
    input  wire logic [imp_pkg::OFF_W-1:0]   core_off,
    input  wire logic [7:0]                  core_wdata,
    output logic                             core_done,
    output logic [7:0]                       core_rdata,
    output logic                             core_flash,
    // Data memory port
    output logic                             mem_req,
    output logic                             mem_we,
    output logic [imp_pkg::MADDR_W-1:0]      mem_addr,
    output logic [7:0]                       mem_wdata,
    input  wire logic [7:0]                  mem_rdata,
    // Program flash read port
    output logic                             flash_req,
    output logic [imp_pkg::FADDR_W-1:0]      flash_addr,
    input  wire logic [imp_pkg::FWORD_W-1:0] flash_rdata,
    // AXI4-Lite slave
    input  wire logic [imp_pkg::AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [imp_pkg::AXI_AW-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        imp_pkg::imp_state_t           st;         // Access sequencer
        imp_pkg::imp_kind_t            kind;       // Target of current access
        logic [15:0]                   ptr0;       // Pointer zero
        logic [15:0]                   ptr1;       // Pointer one
        logic [imp_pkg::BANK_W-1:0]    bank_selector;        // Bank selector
        logic                          mem_req;
        logic                          mem_we;
        logic [imp_pkg::MADDR_W-1:0]   mem_addr;
        logic [7:0]                    mem_wdata;
        logic                          flash_req;
        logic [imp_pkg::FADDR_W-1:0]   flash_addr;
        logic                          core_done;
        logic [7:0]                    core_rdata;
        logic                          core_flash; // Last access outside the core registers went to flash
        logic                          awready;
        logic                          wready;
        logic                          aw_held;    // Write address captured
        logic                          w_held;     // Write data captured
        logic [imp_pkg::IDX_W-1:0]     aw_idx;
        logic [7:0]                    w_byte;
        logic                          w_en;       // Low byte lane enabled
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [7:0]                    rdata;
        logic [1:0]                    rresp;
    } imp_regs_t;

    imp_regs_t r;      // Registered state
    imp_regs_t n;      // Next state

    // ------------------------------------------------------------
    // Pointer decode
    // ------------------------------------------------------------
    // Splits a pointer into banked, linear, gap and flash spaces
    function automatic imp_pkg::imp_map_t map_ptr(input logic [15:0] p);
        imp_pkg::imp_map_t m;
        logic [15:0]       lin;
        logic [15:0]       bnk;
        logic [15:0]       ofs;
        m   = '0;
        lin = p - imp_pkg::LIN_BASE;
        bnk = lin / imp_pkg::GPR_BYTES;
        ofs = (lin % imp_pkg::GPR_BYTES) + imp_pkg::GPR_OFF;
        if (p[imp_pkg::FLASH_BIT]) begin
            m.kind  = imp_pkg::K_FLASH;
            m.faddr = p[imp_pkg::FADDR_W-1:0];
        end else if (p < imp_pkg::LIN_BASE) begin
            m.kind  = imp_pkg::K_MEM;
            m.maddr = p[imp_pkg::MADDR_W-1:0];
        end else if (p <= imp_pkg::LIN_END) begin
            m.maddr = {bnk[imp_pkg::BANK_W-1:0], ofs[imp_pkg::OFF_W-1:0]};
            // Banks with no RAM behind them read as zero
            if (bnk[imp_pkg::BANK_W-1:0] < imp_pkg::IMPL_BANKS) begin
                m.kind = imp_pkg::K_MEM;
            end else begin
                m.kind = imp_pkg::K_ZERO;
            end
        end else begin
            m.kind = imp_pkg::K_ZERO;
        end
        return m;
    endfunction : map_ptr

    // Bus read mux, low byte only
    function automatic logic [8:0] read_reg(input logic [imp_pkg::IDX_W-1:0] idx,
                                            input imp_regs_t s);
        logic [8:0] v;  // {hit, data}
        v = '0;
        unique case (idx)
            imp_pkg::IDX_P0L:  v = {1'b1, s.ptr0[7:0]};
            imp_pkg::IDX_P0H:  v = {1'b1, s.ptr0[15:8]};
            imp_pkg::IDX_P1L:  v = {1'b1, s.ptr1[7:0]};
            imp_pkg::IDX_P1H:  v = {1'b1, s.ptr1[15:8]};
            imp_pkg::IDX_BSR:  v = {1'b1, 3'h0, s.bank_selector};
            imp_pkg::IDX_STAT: v = {1'b1, 5'h00, s.core_flash, s.kind == imp_pkg::K_FLASH,
                                    s.st != imp_pkg::ST_IDLE};
            default:           v = '0;
        endcase
        return v;
    endfunction : read_reg

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        imp_pkg::imp_map_t m;
        logic [15:0]       sel;
        logic [8:0]        rv;
        logic              is_ind;
        m          = '0;
        sel        = '0;
        rv         = '0;
        is_ind     = 1'b0;
        n          = r;
        n.mem_req   = 1'b0;
        n.flash_req = 1'b0;
        n.core_done = 1'b0;

        // Core access sequencer
        unique case (r.st)
            imp_pkg::ST_IDLE: begin
                is_ind = (core_off == imp_pkg::OFF_IND0) || (core_off == imp_pkg::OFF_IND1);
                sel    = (core_off == imp_pkg::OFF_IND0) ? r.ptr0 : r.ptr1;
                if (core_req && is_ind) begin
                    // Indirect port: no storage, follow the pointer
                    m            = map_ptr(sel);
                    n.kind       = m.kind;
                    n.mem_addr   = m.maddr;
                    n.flash_addr = m.faddr;
                    n.mem_wdata  = core_wdata;
                    n.mem_we     = core_we;
                    n.mem_req    = (m.kind == imp_pkg::K_MEM);
                    n.flash_req  = (m.kind == imp_pkg::K_FLASH) && !core_we;
                    n.st         = imp_pkg::ST_ISSUE;
                end else if (core_req) begin
                    // Core registers decode on offset alone, bank ignored
                    unique case (core_off)
                        imp_pkg::OFF_P0L: begin
                            if (core_we) n.ptr0[7:0] = core_wdata;
                            n.core_rdata = r.ptr0[7:0];
                            n.core_done  = 1'b1;
                        end
                        imp_pkg::OFF_P0H: begin
                            if (core_we) n.ptr0[15:8] = core_wdata;
                            n.core_rdata = r.ptr0[15:8];
                            n.core_done  = 1'b1;
                        end
                        imp_pkg::OFF_P1L: begin
                            if (core_we) n.ptr1[7:0] = core_wdata;
                            n.core_rdata = r.ptr1[7:0];
                            n.core_done  = 1'b1;
                        end
                        imp_pkg::OFF_P1H: begin
                            if (core_we) n.ptr1[15:8] = core_wdata;
                            n.core_rdata = r.ptr1[15:8];
                            n.core_done  = 1'b1;
                        end
                        imp_pkg::OFF_BSR: begin
                            if (core_we) n.bank_selector = core_wdata[imp_pkg::BANK_W-1:0];
                            n.core_rdata = {3'h0, r.bank_selector};
                            n.core_done  = 1'b1;
                        end
                        default: begin
                            // Plain banked access through the bank selector
                            n.kind      = imp_pkg::K_MEM;
                            n.mem_addr  = {r.bank_selector, core_off};
                            n.mem_wdata = core_wdata;
                            n.mem_we    = core_we;
                            n.mem_req   = 1'b1;
                            n.st        = imp_pkg::ST_ISSUE;
                        end
                    endcase
                end
            end
            imp_pkg::ST_ISSUE: begin
                // Flash takes one more cycle
                n.st = (r.kind == imp_pkg::K_FLASH) ? imp_pkg::ST_XTRA
                                                    : imp_pkg::ST_RESP;
            end
            imp_pkg::ST_XTRA: begin
                n.st = imp_pkg::ST_RESP;
            end
            imp_pkg::ST_RESP: begin
                // Return data and finish
                unique case (r.kind)
                    imp_pkg::K_MEM:   n.core_rdata = mem_rdata;
                    imp_pkg::K_FLASH: n.core_rdata = flash_rdata[7:0];
                    default:          n.core_rdata = imp_pkg::ZERO_BYTE;
                endcase
                n.core_flash = (r.kind == imp_pkg::K_FLASH);
                n.core_done  = 1'b1;
                n.st         = imp_pkg::ST_IDLE;
            end
        endcase

        // Bus write: address and data in either order
        if (s_axi_awvalid && r.awready) begin
            n.aw_held = 1'b1;
            n.aw_idx  = s_axi_awaddr[imp_pkg::AXI_AW-1:2];
            n.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_held = 1'b1;
            n.w_byte = s_axi_wdata[7:0];
            n.w_en   = s_axi_wstrb[0];
            n.wready = 1'b0;
        end
        if (r.aw_held && r.w_held && !r.bvalid) begin
            // Bus write wins over a core write in the same cycle
            rv      = read_reg(r.aw_idx, r);
            n.bresp = rv[8] ? imp_pkg::RESP_OKAY : imp_pkg::RESP_SLVERR;
            n.bvalid = 1'b1;
            if (r.w_en) begin
                unique case (r.aw_idx)
                    imp_pkg::IDX_P0L: n.ptr0[7:0]  = r.w_byte;
                    imp_pkg::IDX_P0H: n.ptr0[15:8] = r.w_byte;
                    imp_pkg::IDX_P1L: n.ptr1[7:0]  = r.w_byte;
                    imp_pkg::IDX_P1H: n.ptr1[15:8] = r.w_byte;
                    imp_pkg::IDX_BSR: n.bank_selector = r.w_byte[imp_pkg::BANK_W-1:0];
                    default:          n.bank_selector = n.bank_selector;
                endcase
            end
        end
        if (r.bvalid && s_axi_bready) begin
            // Response taken, reopen both channels
            n.bvalid  = 1'b0;
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.awready = 1'b1;
            n.wready  = 1'b1;
        end

        // Bus read
        if (s_axi_arvalid && r.arready) begin
            rv        = read_reg(s_axi_araddr[imp_pkg::AXI_AW-1:2], r);
            n.rdata   = rv[7:0];
            n.rresp   = rv[8] ? imp_pkg::RESP_OKAY : imp_pkg::RESP_SLVERR;
            n.rvalid  = 1'b1;
            n.arready = 1'b0;
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r         <= '0;
            r.st      <= imp_pkg::ST_IDLE;
            r.kind    <= imp_pkg::K_MEM;
            r.ptr0    <= imp_pkg::PTR_RST;
            r.ptr1    <= imp_pkg::PTR_RST;
            r.bank_selector     <= imp_pkg::BSR_RST;
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from the state register
    // ------------------------------------------------------------
    assign core_done     = r.core_done;
    assign core_rdata    = r.core_rdata;
    assign core_flash    = r.core_flash;
    assign mem_req       = r.mem_req;
    assign mem_we        = r.mem_we;
    assign mem_addr      = r.mem_addr;
    assign mem_wdata     = r.mem_wdata;
    assign flash_req     = r.flash_req;
    assign flash_addr    = r.flash_addr;
    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rdata   = {24'h000000, r.rdata};

endmodule : imp_pointer_map

`default_nettype wire

// File: imp_pointer_map_checker.sv
// Concurrent checks on the ports of the indirect pointer map
`timescale 1ns/10ps
`default_nettype none
module imp_pointer_map_checker (
    // Clock and reset
    input wire logic                        aclk,
    input wire logic                        aresetn,
    // Core port
    input wire logic                        core_req,
    input wire logic [imp_pkg::OFF_W-1:0]   core_off,
    input wire logic                        core_done,
    input wire logic [7:0]                  core_rdata,
    input wire logic                        core_flash,
    // Memory and flash ports
    input wire logic                        mem_req,
    input wire logic                        flash_req,
    input wire logic [imp_pkg::FWORD_W-1:0] flash_rdata,
    // Register bus
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Busy from an accepted request until its done
    logic busy_r;
    always_ff @(posedge aclk) begin
        busy_r <= aresetn && !core_done && (busy_r || core_req);
    end
    AST_LOCAL_ONE: assert property (core_req && !busy_r && core_off inside {[7'h04:7'h08]}
        |=> core_done) else $error("local access not done in one cycle");
    AST_MEM_LAT: assert property (mem_req |-> ##2 (core_done && !core_flash))
        else $error("memory access done at wrong time");
    AST_FLASH_LAT: assert property (flash_req |-> !core_done [*3] ##1 (core_done && core_flash))
        else $error("flash access not one cycle longer");
    AST_FLASH_BYTE: assert property (flash_req ##3 core_done |-> core_rdata == flash_rdata[7:0])
        else $error("flash read not low byte");
    AST_ONE_SPACE: assert property (!(mem_req && flash_req))
        else $error("memory and flash requested together");
    AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_AW_LOW: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("write address taken twice");
endmodule : imp_pointer_map_checker
bind imp_pointer_map imp_pointer_map_checker u_chk (.*);
`default_nettype wire

// File: imp_mem_model.sv
// Data memory and program flash seen by the pointer map
`timescale 1ns/10ps
`default_nettype none
module imp_mem_model (
    // Clock
    input wire logic         aclk,
    // Data memory port
    input wire logic         mem_req,
    input wire logic         mem_we,
    input wire logic [11:0]  mem_addr,
    input wire logic [7:0]   mem_wdata,
    output var logic [7:0]   mem_rdata,
    // Flash read port, no write path at all
    input wire logic         flash_req,
    input wire logic [14:0]  flash_addr,
    output var logic [13:0]  flash_rdata
);
    logic [7:0] ram [4096];  // Byte store with an address-derived preset
    initial begin
        for (int i = 0; i < 4096; i++) ram[i] = 8'(i) ^ {4'(i >> 8), 4'hA};
        mem_rdata = 8'h00;
        flash_rdata = 14'h0000;
    end
    // Answer one cycle after a request; after a write the bus shows junk
    always @(posedge aclk) begin
        if (mem_req) begin
            if (mem_we) ram[mem_addr] <= mem_wdata;
            mem_rdata <= mem_we ? ~mem_rdata : ram[mem_addr];
        end
        if (flash_req) flash_rdata <= {flash_addr[5:0], flash_addr[7:0] ^ 8'hA5};
    end
endmodule : imp_mem_model
`default_nettype wire

// File: test_imp_pointer_map.sv
// Self-checking testbench for the indirect pointer map
`timescale 1ns/10ps
`default_nettype none
module test_imp_pointer_map;
    // One table row: pointer, memory address, kind 0 mem 1 zero 2 flash
    typedef struct packed {logic [15:0] ptr; logic [11:0] addr; logic [1:0] kind;} imp_row_t;
    imp_row_t rows [10] = '{'{16'h0123, 12'h123, 2'h0}, '{16'h2000, 12'h020, 2'h0},
        '{16'h204F, 12'h06F, 2'h0}, '{16'h2050, 12'h0A0, 2'h0}, '{16'h20A0, 12'h000, 2'h1},
        '{16'h29AF, 12'h000, 2'h1}, '{16'h29B0, 12'h000, 2'h1}, '{16'h7FFF, 12'h000, 2'h1},
        '{16'h8000, 12'h000, 2'h2}, '{16'hFFFF, 12'h000, 2'h2}};
    logic aclk = 1'b0, aresetn = 1'b0, core_req = 1'b0, core_we = 1'b0;
    logic [6:0] core_off = 7'h00;
    logic [7:0] core_wdata = 8'h00, core_rdata, mem_wdata, mem_rdata, rd, exp8;
    logic core_done, core_flash, mem_req, mem_we, flash_req;
    logic [11:0] mem_addr;
    logic [14:0] flash_addr;
    logic [13:0] flash_rdata;
    logic [12:0] s_axi_awaddr = 13'h0000, s_axi_araddr = 13'h0000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ard;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, ares;
    int n_mismatch = 0, checked = 0, cyc, n_memw = 0, n0;
    imp_pointer_map uut (.*);
    imp_mem_model u_mem (.*);
    always #5 aclk = ~aclk;
    // Stray memory writes
    always @(posedge aclk) if (mem_req === 1'b1 && mem_we === 1'b1) n_memw++;
    function automatic logic [7:0] ram_of(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'hA};
    endfunction : ram_of
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // One core access, cycles counted from the taking edge to done
    task automatic core(input logic we, input logic [6:0] off, input logic [7:0] wd);
        @(posedge aclk);
        core_req <= 1'b1;
        core_we <= we;
        core_off <= off;
        core_wdata <= wd;
        @(posedge aclk);
        core_req <= 1'b0;
        cyc = 1;
        #1;
        while (core_done !== 1'b1 && cyc < 20) begin
            @(posedge aclk);
            #1;
            cyc++;
        end
        rd = core_rdata;
    endtask : core
    task automatic setp(input logic p, input logic [15:0] v);
        core(1'b1, p ? 7'h06 : 7'h04, v[7:0]);
        core(1'b1, p ? 7'h07 : 7'h05, v[15:8]);
    endtask : setp
    // Bus write
    task automatic axi_wr(input logic [10:0] idx, input logic [31:0] d, input logic [3:0] st);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        ares = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [10:0] idx);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        ard = s_axi_rdata;
        ares = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    initial begin
        #100us;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, then an unmapped index and the port index
        for (int j = 0; j < 7; j++) begin
            axi_rd(j < 5 ? 11'(11'h404 + j) : (j == 5 ? 11'h409 : imp_pkg::IDX_IND0));
            check("reg_reset", ard, 32'h0);
            check("reg_resp", ares, j < 5 ? imp_pkg::RESP_OKAY : imp_pkg::RESP_SLVERR);
        end
        // Ordinary indirect reads, alternating the two ports
        foreach (rows[i]) begin
            setp(i[0], rows[i].ptr);
            core(1'b0, {6'h00, i[0]}, 8'h00);
            exp8 = rows[i].kind == 2'h2 ? rows[i].ptr[7:0] ^ 8'hA5 : 8'h00;
            exp8 = rows[i].kind == 2'h0 ? ram_of(rows[i].addr) : exp8;
            check("ind_data", rd, exp8);
            check("ind_cycles", cyc, rows[i].kind == 2'h2 ? 4 : 3);
            check("ind_flash", core_flash, rows[i].kind == 2'h2);
        end
        // Bus sets pointer zero to a linear address; masked write dropped
        axi_wr(imp_pkg::IDX_P0L, 32'h21, 4'hF);
        axi_wr(imp_pkg::IDX_P0H, 32'h20, 4'hF);
        axi_wr(imp_pkg::IDX_P0H, 32'h55, 4'h0);
        check("wr_resp", ares, imp_pkg::RESP_OKAY);
        axi_rd(imp_pkg::IDX_P0H);
        check("p0h_keep", ard, 32'h20);
        core(1'b1, 7'h00, 8'hC3);
        setp(1'b0, 16'h0041);
        core(1'b0, 7'h00, 8'h00);
        check("lin_write", rd, 8'hC3);
        // Core registers in another bank, plain offset goes to that bank
        axi_wr(imp_pkg::IDX_BSR, 32'h03, 4'hF);
        core(1'b0, 7'h08, 8'h00);
        check("bank_rd", rd, 8'h03);
        check("local_cyc", cyc, 1);
        core(1'b1, 7'h30, 8'h5C);
        setp(1'b1, 16'h01B0);
        core(1'b0, 7'h01, 8'h00);
        check("bank_wr", rd, 8'h5C);
        // Writes into flash and the gap change nothing
        n0 = n_memw;
        setp(1'b0, 16'h8005);
        core(1'b1, 7'h00, 8'h3C);
        check("fl_wr_cyc", cyc, 4);
        core(1'b0, 7'h00, 8'h00);
        check("fl_keep", rd, 8'hA0);
        setp(1'b0, 16'h3000);
        core(1'b1, 7'h00, 8'h3C);
        core(1'b0, 7'h00, 8'h00);
        check("gap_rd", rd, 8'h00);
        check("no_mem_wr", n_memw, n0);
        // Second reset clears the high byte of pointer one
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(imp_pkg::IDX_P1H);
        check("p1h_rst", ard, 32'h0);
        conclude();
    end
endmodule : test_imp_pointer_map
`default_nettype wire
